/* src/raf_pkg.sv */
// shared constants and types of the rtc alarm compare and flag block
package raf_pkg;
  // register byte offsets on the bus
  localparam logic [31:0] OFS_SECOND_ALARM = 32'h0000_0000;
  localparam logic [31:0] OFS_MINUTE_ALARM = 32'h0000_0004;
  localparam logic [31:0] OFS_HOUR_ALARM = 32'h0000_0008;
  localparam logic [31:0] OFS_WEEKDAY_ALARM = 32'h0000_000c;
  localparam logic [31:0] OFS_DAY_ALARM = 32'h0000_0010;
  localparam logic [31:0] OFS_MONTH_ALARM = 32'h0000_0014;
  localparam logic [31:0] OFS_FLAG_CONTROL_ONE = 32'h0000_0018;
  // alarm slot indices, also the decoder's answer
  localparam logic [2:0] IDX_SECOND = 3'h0;
  localparam logic [2:0] IDX_MINUTE = 3'h1;
  localparam logic [2:0] IDX_HOUR = 3'h2;
  localparam logic [2:0] IDX_WEEKDAY = 3'h3;
  localparam logic [2:0] IDX_DAY = 3'h4;
  localparam logic [2:0] IDX_MONTH = 3'h5;
  localparam logic [2:0] IDX_CONTROL = 3'h6;
  localparam logic [2:0] IDX_NONE = 3'h7;
  localparam int unsigned N_ALARM = 6;
  // writable bits of each alarm register, bit 7 is the field enable
  localparam logic [7:0] MASK_SECOND = 8'hff;
  localparam logic [7:0] MASK_MINUTE = 8'hff;
  localparam logic [7:0] MASK_HOUR = 8'hbf;
  localparam logic [7:0] MASK_WEEKDAY = 8'h87;
  localparam logic [7:0] MASK_DAY = 8'hbf;
  localparam logic [7:0] MASK_MONTH = 8'h9f;
  // compare masks, enable bit stripped
  localparam logic [6:0] CMP_MASK_ALL = 7'h7f;
  // bit positions
  localparam int unsigned ENB_BIT = 7;
  localparam int unsigned CARRY_FLAG_BIT = 7;
  localparam int unsigned CARRY_IRQ_EN_BIT = 4;
  localparam int unsigned ALARM_IRQ_EN_BIT = 3;
  localparam int unsigned ALARM_FLAG_BIT = 0;
  // ahb encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;
  // match evaluation sequencer, one-hot
  typedef enum logic [1:0] {
    RAF_EV_IDLE = 2'b01,
    RAF_EV_EVAL = 2'b10
  } raf_eval_t;
  // whole state of the top module
  typedef struct packed {
    logic [5:0][7:0] alarm;
    logic carry_flag;
    logic carry_irq_enable;
    logic alarm_irq_enable;
    logic alarm_flag;
    raf_eval_t ev;
    logic [31:0] hrdata;
    logic hreadyout;
    logic carry_irq;
    logic alarm_irq;
    logic [2:0] last_rd;
  } raf_top_state_t;
  // state of the bus port
  typedef struct packed {
    logic wr_pend;
    logic [31:0] wr_addr;
  } raf_port_state_t;
endpackage : raf_pkg

/* src/raf_field_match.sv */
// one alarm field compared with its running counter
`timescale 1ns/1ps
module raf_field_match (
  input wire logic enable,
  input wire logic [6:0] alarm_value,
  input wire logic [6:0] count_value,
  input wire logic [6:0] value_mask,
  output logic hit
);
  // a disabled field always counts as a hit so it drops out of the match
  always_comb begin
    hit = !enable || (((alarm_value ^ count_value) & value_mask) == 7'h00);
  end
endmodule : raf_field_match

/* src/raf_ahb_port.sv */
// ahb-lite slave front end: takes address phases, presents writes in data phase
`timescale 1ns/1ps
module raf_ahb_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic wr_en,
  output logic [31:0] wr_addr,
  output logic rd_en,
  output logic [31:0] rd_addr
);
  raf_pkg::raf_port_state_t state_reg; // registered address phase
  raf_pkg::raf_port_state_t state_next; // its next value
  logic take; // an active transfer is accepted this edge

  // accept nonseq or seq transfers only while the bus is ready
  always_comb begin
    take = hsel && hready && htrans[1];
    state_next = state_reg;
    state_next.wr_pend = take && hwrite;
    if (take && hwrite) begin
      state_next.wr_addr = haddr;
    end
    rd_en = take && !hwrite;
    rd_addr = haddr;
    wr_en = state_reg.wr_pend;
    wr_addr = state_reg.wr_addr;
  end

  // register the address phase
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule : raf_ahb_port

/* src/raf_alarm_flags.sv */
// rtc alarm registers, alarm match and carry / alarm flag logic
`timescale 1ns/1ps
module raf_alarm_flags (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic MANUAL_RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [7:0] SECOND_COUNT,
  input wire logic [7:0] MINUTE_COUNT,
  input wire logic [7:0] HOUR_COUNT,
  input wire logic [7:0] WEEKDAY_COUNT,
  input wire logic [7:0] DAY_COUNT,
  input wire logic [7:0] MONTH_COUNT,
  input wire logic COUNT_UPDATE,
  input wire logic SECOND_CARRY,
  input wire logic FAST_CARRY_READ,
  output logic CARRY_IRQ,
  output logic ALARM_IRQ
);
  // writable bits per alarm slot
  localparam logic [5:0][7:0] WR_MASK = {raf_pkg::MASK_MONTH, raf_pkg::MASK_DAY,
    raf_pkg::MASK_WEEKDAY, raf_pkg::MASK_HOUR, raf_pkg::MASK_MINUTE, raf_pkg::MASK_SECOND};

  raf_pkg::raf_top_state_t state_reg; // all registered state
  raf_pkg::raf_top_state_t state_next; // its next value
  logic wr_en; // write data phase now
  logic [31:0] wr_addr; // address of that write
  logic rd_en; // read address phase taken now
  logic [31:0] rd_addr; // address of that read
  logic [5:0][7:0] counts; // running counters by slot
  logic [5:0] hit; // per field match or disabled
  logic any_en; // at least one field enabled
  logic all_match; // every enabled field matches and at least one is enabled
  logic [2:0] wsel; // decoded write target
  logic [2:0] rsel; // decoded read target

  // map an address to an alarm slot, the control register or nothing
  function automatic logic [2:0] addr_sel(input logic [31:0] a);
    logic [2:0] r;
    r = raf_pkg::IDX_NONE;
    case ({a[31:2], 2'b00})
      raf_pkg::OFS_SECOND_ALARM: r = raf_pkg::IDX_SECOND;
      raf_pkg::OFS_MINUTE_ALARM: r = raf_pkg::IDX_MINUTE;
      raf_pkg::OFS_HOUR_ALARM: r = raf_pkg::IDX_HOUR;
      raf_pkg::OFS_WEEKDAY_ALARM: r = raf_pkg::IDX_WEEKDAY;
      raf_pkg::OFS_DAY_ALARM: r = raf_pkg::IDX_DAY;
      raf_pkg::OFS_MONTH_ALARM: r = raf_pkg::IDX_MONTH;
      raf_pkg::OFS_FLAG_CONTROL_ONE: r = raf_pkg::IDX_CONTROL;
      default: r = raf_pkg::IDX_NONE;
    endcase
    return r;
  endfunction : addr_sel

  // read value of a target, unmapped reads as zero
  function automatic logic [31:0] read_word(input logic [2:0] sel, input raf_pkg::raf_top_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (sel < raf_pkg::IDX_CONTROL) begin
      w[7:0] = s.alarm[sel] & WR_MASK[sel];
    end else if (sel == raf_pkg::IDX_CONTROL) begin
      w[raf_pkg::CARRY_FLAG_BIT] = s.carry_flag;
      w[raf_pkg::CARRY_IRQ_EN_BIT] = s.carry_irq_enable;
      w[raf_pkg::ALARM_IRQ_EN_BIT] = s.alarm_irq_enable;
      w[raf_pkg::ALARM_FLAG_BIT] = s.alarm_flag;
    end
    return w;
  endfunction : read_word

  // bus front end
  raf_ahb_port u_port (
    .clk(CLK),
    .reset(RESET),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hready(HREADY),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .rd_en(rd_en),
    .rd_addr(rd_addr)
  );

  // counters in slot order
  always_comb begin
    counts = {MONTH_COUNT, DAY_COUNT, WEEKDAY_COUNT, HOUR_COUNT, MINUTE_COUNT, SECOND_COUNT};
  end

  // one comparator per alarm field
  for (genvar g = 0; g < raf_pkg::N_ALARM; g++) begin : g_match
    raf_field_match u_match (
      .enable(state_reg.alarm[g][raf_pkg::ENB_BIT]),
      .alarm_value(state_reg.alarm[g][6:0]),
      .count_value(counts[g][6:0]),
      .value_mask(raf_pkg::CMP_MASK_ALL & WR_MASK[g][6:0]),
      .hit(hit[g])
    );
  end

  // combine the fields: all must hit and one must be enabled
  always_comb begin
    any_en = 1'b0;
    for (int i = 0; i < raf_pkg::N_ALARM; i++) begin
      any_en = any_en | state_reg.alarm[i][raf_pkg::ENB_BIT];
    end
    all_match = (&hit) && any_en;
  end

  // next state: writes, hardware sets, evaluation, interrupts, read data
  always_comb begin
    state_next = state_reg;
    wsel = addr_sel(wr_addr);
    rsel = addr_sel(rd_addr);
    // register writes take the low byte, reserved bits dropped
    if (wr_en && wsel < raf_pkg::IDX_CONTROL) begin
      state_next.alarm[wsel] = HWDATA[7:0] & WR_MASK[wsel];
    end else if (wr_en && wsel == raf_pkg::IDX_CONTROL) begin
      state_next.carry_flag = HWDATA[raf_pkg::CARRY_FLAG_BIT];
      state_next.carry_irq_enable = HWDATA[raf_pkg::CARRY_IRQ_EN_BIT];
      state_next.alarm_irq_enable = HWDATA[raf_pkg::ALARM_IRQ_EN_BIT];
      if (!HWDATA[raf_pkg::ALARM_FLAG_BIT]) begin
        state_next.alarm_flag = 1'b0;
      end
    end
    // carry events win over a clearing write
    if (SECOND_CARRY || FAST_CARRY_READ) begin
      state_next.carry_flag = 1'b1;
    end
    // manual reset drops both interrupt enables
    if (MANUAL_RESET) begin
      state_next.carry_irq_enable = 1'b0;
      state_next.alarm_irq_enable = 1'b0;
    end
    // evaluate once, the cycle after the counters moved
    case (state_reg.ev)
      raf_pkg::RAF_EV_IDLE: begin
        if (COUNT_UPDATE) begin
          state_next.ev = raf_pkg::RAF_EV_EVAL;
        end
      end
      raf_pkg::RAF_EV_EVAL: begin
        if (all_match) begin
          state_next.alarm_flag = 1'b1;
        end
        state_next.ev = COUNT_UPDATE ? raf_pkg::RAF_EV_EVAL : raf_pkg::RAF_EV_IDLE;
      end
      default: begin
        state_next.ev = raf_pkg::RAF_EV_IDLE;
      end
    endcase
    // interrupt requests follow flag and enable
    state_next.carry_irq = state_next.carry_flag && state_next.carry_irq_enable;
    state_next.alarm_irq = state_next.alarm_flag && state_next.alarm_irq_enable;
    // read data from the next state so a read right after a write sees it
    if (rd_en) begin
      state_next.hrdata = read_word(rsel, state_next);
      state_next.last_rd = rsel;
    end
    state_next.hreadyout = 1'b1;
  end

  // register everything; reset touches control state, not alarm values
  always_ff @(posedge CLK) begin
    state_reg <= state_next;
    if (RESET) begin
      for (int i = 0; i < raf_pkg::N_ALARM; i++) begin
        state_reg.alarm[i][raf_pkg::ENB_BIT] <= 1'b0;
      end
      state_reg.carry_flag <= 1'b0;
      state_reg.carry_irq_enable <= 1'b0;
      state_reg.alarm_irq_enable <= 1'b0;
      state_reg.alarm_flag <= 1'b0;
      state_reg.ev <= raf_pkg::RAF_EV_IDLE;
      state_reg.hrdata <= 32'h0000_0000;
      state_reg.hreadyout <= 1'b1;
      state_reg.carry_irq <= 1'b0;
      state_reg.alarm_irq <= 1'b0;
      state_reg.last_rd <= raf_pkg::IDX_NONE;
    end
  end

  // outputs straight from flops, HRESP tied to okay
  always_comb begin
    HRDATA = state_reg.hrdata;
    HREADYOUT = state_reg.hreadyout;
    HRESP = raf_pkg::HRESP_OKAY;
    CARRY_IRQ = state_reg.carry_irq;
    ALARM_IRQ = state_reg.alarm_irq;
  end

  // full match during evaluation raises the alarm flag next edge
  a_alarm_set_match: assert property (@(posedge CLK) disable iff (RESET)
    (state_reg.ev == raf_pkg::RAF_EV_EVAL) && all_match |=> state_reg.alarm_flag)
    else $error("alarm flag not set on full match");

  // a mismatching enabled hour field blocks the flag from rising
  a_hour_blocks_flag: assert property (@(posedge CLK) disable iff (RESET)
    state_reg.alarm[raf_pkg::IDX_HOUR][raf_pkg::ENB_BIT]
    && (state_reg.alarm[raf_pkg::IDX_HOUR][5:0] != HOUR_COUNT[5:0]) |=> !$rose(state_reg.alarm_flag))
    else $error("alarm flag rose despite hour mismatch");

  // the flag only rises after an evaluation with something enabled
  a_flag_needs_enable: assert property (@(posedge CLK) disable iff (RESET)
    $rose(state_reg.alarm_flag) |-> $past(any_en) && ($past(state_reg.ev) == raf_pkg::RAF_EV_EVAL))
    else $error("alarm flag rose without enabled match");

  // an update is evaluated exactly in the next cycle
  a_eval_after_update: assert property (@(posedge CLK) disable iff (RESET)
    COUNT_UPDATE |=> (state_reg.ev == raf_pkg::RAF_EV_EVAL))
    else $error("no evaluation after counter update");

  // carry events set the carry flag
  a_carry_set: assert property (@(posedge CLK) disable iff (RESET)
    SECOND_CARRY || FAST_CARRY_READ |=> state_reg.carry_flag)
    else $error("carry flag not set by carry");

  // writing zero clears the carry flag when no carry arrives
  a_carry_write_zero: assert property (@(posedge CLK) disable iff (RESET)
    wr_en && (wsel == raf_pkg::IDX_CONTROL) && !HWDATA[raf_pkg::CARRY_FLAG_BIT]
    && !SECOND_CARRY && !FAST_CARRY_READ |=> !state_reg.carry_flag)
    else $error("carry flag not cleared by write");

  // writing zero clears the alarm flag unless a match lands
  a_alarm_write_zero: assert property (@(posedge CLK) disable iff (RESET)
    wr_en && (wsel == raf_pkg::IDX_CONTROL) && !HWDATA[raf_pkg::ALARM_FLAG_BIT]
    && !((state_reg.ev == raf_pkg::RAF_EV_EVAL) && all_match) |=> !state_reg.alarm_flag)
    else $error("alarm flag not cleared by write");

  // the carry request mirrors flag and enable
  a_carry_irq_tie: assert property (@(posedge CLK) disable iff (RESET)
    CARRY_IRQ == (state_reg.carry_flag && state_reg.carry_irq_enable))
    else $error("carry irq disagrees with flag and enable");

  // the alarm request mirrors flag and enable
  a_alarm_irq_tie: assert property (@(posedge CLK) disable iff (RESET)
    ALARM_IRQ == (state_reg.alarm_flag && state_reg.alarm_irq_enable))
    else $error("alarm irq disagrees with flag and enable");

  // manual reset leaves both enables clear
  a_manual_reset_ien: assert property (@(posedge CLK) disable iff (RESET)
    MANUAL_RESET |=> !state_reg.carry_irq_enable && !state_reg.alarm_irq_enable)
    else $error("irq enables survived manual reset");

  // hour and day bit 6 read back as zero
  a_hour_day_bit6: assert property (@(posedge CLK) disable iff (RESET)
    (state_reg.last_rd == raf_pkg::IDX_HOUR) || (state_reg.last_rd == raf_pkg::IDX_DAY) |-> !HRDATA[6])
    else $error("bit 6 of hour or day alarm read as one");

  // weekday reserved bits read back as zero
  a_weekday_reserved: assert property (@(posedge CLK) disable iff (RESET)
    (state_reg.last_rd == raf_pkg::IDX_WEEKDAY) |-> (HRDATA[6:3] == 4'h0))
    else $error("weekday reserved bits read as one");

  // month reserved bits read back as zero
  a_month_reserved: assert property (@(posedge CLK) disable iff (RESET)
    (state_reg.last_rd == raf_pkg::IDX_MONTH) |-> (HRDATA[6:5] == 2'h0))
    else $error("month reserved bits read as one");

  // control reserved bits read back as zero
  a_control_reserved: assert property (@(posedge CLK) disable iff (RESET)
    (state_reg.last_rd == raf_pkg::IDX_CONTROL) |-> (HRDATA[6:5] == 2'h0) && (HRDATA[2:1] == 2'h0))
    else $error("control reserved bits read as one");

  // after power-on reset no alarm field is enabled
  a_enables_cleared: assert property (@(posedge CLK)
    RESET |=> !any_en)
    else $error("alarm enable survived reset");

  // the slave never stalls
  a_ready_always: assert property (@(posedge CLK) disable iff (RESET)
    HREADYOUT && (HRESP == raf_pkg::HRESP_OKAY))
    else $error("slave stalled or erred");
endmodule : raf_alarm_flags

/* verif/rtc_alarm_compare_and_flags_bench.sv */
// self-checking bench of the rtc alarm compare and flag block
`timescale 1ns/1ps
module rtc_alarm_compare_and_flags_bench;
  // stimulus pins, all given a value at time zero
  logic CLK = 1'b0, RESET = 1'b1, MANUAL_RESET = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
  logic [1:0] HTRANS = raf_pkg::HTRANS_IDLE;
  logic [2:0] HSIZE = 3'h2;
  logic [7:0] cnt [6] = '{default: 8'h00};
  logic COUNT_UPDATE = 1'b0, SECOND_CARRY = 1'b0, FAST_CARRY_READ = 1'b0;
  // observed pins
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, CARRY_IRQ, ALARM_IRQ, HREADY;
  // bookkeeping
  int n_fail = 0, samples_checked = 0, cycles = 0;
  logic [31:0] seed = 32'h0000_7a1e; // 31262
  // legal value ranges of second, minute, hour, weekday, day, month
  int lo [6] = '{0, 0, 0, 0, 1, 1};
  int hi [6] = '{59, 59, 23, 6, 31, 12};
  logic [7:0] msk [6] = '{raf_pkg::MASK_SECOND, raf_pkg::MASK_MINUTE, raf_pkg::MASK_HOUR,
                          raf_pkg::MASK_WEEKDAY, raf_pkg::MASK_DAY, raf_pkg::MASK_MONTH};
  localparam logic [31:0] CTRL = raf_pkg::OFS_FLAG_CONTROL_ONE;

  // single slave, so its ready is the bus ready
  assign HREADY = HREADYOUT;

  raf_alarm_flags raf_alarm_flags_i (
    .CLK(CLK), .RESET(RESET), .MANUAL_RESET(MANUAL_RESET), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SECOND_COUNT(cnt[0]),
    .MINUTE_COUNT(cnt[1]), .HOUR_COUNT(cnt[2]), .WEEKDAY_COUNT(cnt[3]), .DAY_COUNT(cnt[4]),
    .MONTH_COUNT(cnt[5]), .COUNT_UPDATE(COUNT_UPDATE), .SECOND_CARRY(SECOND_CARRY),
    .FAST_CARRY_READ(FAST_CARRY_READ), .CARRY_IRQ(CARRY_IRQ), .ALARM_IRQ(ALARM_IRQ)
  );

  // 200 mhz clock
  initial begin
    forever #2.5 CLK = ~CLK;
  end

  // hang guard, well above the roughly 1040 cycles the tests need
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      $display("[FAIL] timeout expected finish seen hang");
      n_fail++;
      end_of_test();
    end
  end

  // xorshift source of random values
  function automatic logic [31:0] xrand();
    logic [31:0] x;
    x = seed;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    seed = x;
    return x;
  endfunction : xrand

  // decimal to packed bcd
  function automatic logic [7:0] bcd(input int v);
    return 8'(((v / 10) << 4) | (v % 10));
  endfunction : bcd

  // random legal bcd value of field i, software never writes out of range
  function automatic logic [7:0] rnd_field(input int i);
    return bcd(lo[i] + int'(xrand() % 32'(hi[i] - lo[i] + 1)));
  endfunction : rnd_field

  // one comparison, counted
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : check

  // next rising edge at which hready is high
  task automatic wait_ready();
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
  endtask : wait_ready

  // single word write, entered just after a rising edge
  task automatic bus_write(input logic [31:0] a, input logic [7:0] d);
    HSEL <= 1'b1;
    HTRANS <= raf_pkg::HTRANS_NONSEQ;
    HWRITE <= 1'b1;
    HADDR <= a;
    wait_ready();
    HTRANS <= raf_pkg::HTRANS_IDLE;
    HWDATA <= {24'h0, d};
    wait_ready();
  endtask : bus_write

  // single word read compared with the expected value
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    HSEL <= 1'b1;
    HTRANS <= raf_pkg::HTRANS_NONSEQ;
    HWRITE <= 1'b0;
    HADDR <= a;
    wait_ready();
    HTRANS <= raf_pkg::HTRANS_IDLE;
    wait_ready();
    check($sformatf("hrdata at %h", a), exp, HRDATA);
    check("hresp", 32'(raf_pkg::HRESP_OKAY), 32'(HRESP));
  endtask : rchk

  // verdict, the one place the run ends
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // main sequence
  initial begin
    logic [5:0] en;
    logic hit;
    logic [7:0] av [6];
    logic [7:0] cv [6];
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    // reset state and an unmapped place
    rchk(CTRL, 32'h0);
    bus_write(32'h0000_001c, 8'hff);
    rchk(32'h0000_001c, 32'h0);
    check("irqs after reset", 32'h0, {30'h0, CARRY_IRQ, ALARM_IRQ});
    $display("test reset done");
    // read-only zero bits of every alarm, reserved and flag bits of control
    for (int i = 0; i < 6; i++) begin
      bus_write(raf_pkg::OFS_SECOND_ALARM + 32'(4 * i), 8'hff);
      rchk(raf_pkg::OFS_SECOND_ALARM + 32'(4 * i), {24'h0, msk[i]});
    end
    bus_write(CTRL, 8'hff);
    rchk(CTRL, 32'h98);
    #1;
    check("carry irq", 32'h1, {31'h0, CARRY_IRQ});
    check("alarm irq", 32'h0, {31'h0, ALARM_IRQ});
    @(posedge CLK);
    $display("test masks done");
    // both carry sources, with and without the carry irq enable
    for (int k = 0; k < 4; k++) begin
      bus_write(CTRL, {3'h0, k[1], 4'h0});
      if (k[0]) begin
        SECOND_CARRY <= 1'b1;
      end else begin
        FAST_CARRY_READ <= 1'b1;
      end
      // look once the landing edge has settled
      #1;
      check("carry irq cleared", 32'h0, {31'h0, CARRY_IRQ});
      @(posedge CLK);
      SECOND_CARRY <= 1'b0;
      FAST_CARRY_READ <= 1'b0;
      #1;
      check("carry irq set", {31'h0, k[1]}, {31'h0, CARRY_IRQ});
      @(posedge CLK);
      rchk(CTRL, {24'h0, 1'b1, 2'h0, k[1], 4'h0});
    end
    $display("test carry done");
    // manual reset clears only the irq enables
    bus_write(CTRL, 8'h98);
    MANUAL_RESET <= 1'b1;
    @(posedge CLK);
    MANUAL_RESET <= 1'b0;
    @(posedge CLK);
    rchk(CTRL, 32'h80);
    $display("test manual reset done");
    // random alarm settings against random counters, first with no field enabled
    for (int it = 0; it < 40; it++) begin
      en = (it == 0) ? 6'h00 : 6'(xrand());
      hit = 1'b1;
      for (int i = 0; i < 6; i++) begin
        av[i] = rnd_field(i);
        cv[i] = ((xrand() & 32'h1) != 0) ? av[i] : rnd_field(i);
        if (en[i] && cv[i] != av[i]) begin
          hit = 1'b0;
        end
        bus_write(raf_pkg::OFS_SECOND_ALARM + 32'(4 * i), {en[i], av[i][6:0]});
      end
      if (en == 6'h00) begin
        hit = 1'b0;
      end
      bus_write(CTRL, 8'h08);
      for (int i = 0; i < 6; i++) begin
        cnt[i] <= cv[i];
      end
      COUNT_UPDATE <= 1'b1;
      @(posedge CLK);
      COUNT_UPDATE <= 1'b0;
      repeat (2) @(posedge CLK);
      #1;
      check("alarm irq", {31'h0, hit}, {31'h0, ALARM_IRQ});
      @(posedge CLK);
      rchk(CTRL, 32'h08 | 32'(hit));
      bus_write(CTRL, 8'h09);
      rchk(CTRL, 32'h08 | 32'(hit));
    end
    $display("test match done");
    // power-on reset drops the enable and keeps the alarm value
    bus_write(raf_pkg::OFS_HOUR_ALARM, 8'h85);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    rchk(raf_pkg::OFS_HOUR_ALARM, 32'h05);
    rchk(CTRL, 32'h0);
    $display("test power-on reset done");
    end_of_test();
  end
endmodule : rtc_alarm_compare_and_flags_bench
